// file: pkg/ssc_pkg.sv
// Constants and types for the sequencer step configuration register block
package ssc_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CFG_W  = 16;
	localparam int unsigned IDX_W  = 10;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] STEP_TEN_INDEX     = 10'h009a;
	localparam logic [IDX_W-1:0] STEP_ELEVEN_INDEX  = 10'h009b;
	localparam logic [IDX_W-1:0] ROUTE_STATUS_INDEX = 10'h00a0;

	localparam logic [CFG_W-1:0] STEP_TEN_RESET    = 16'h000a;
	localparam logic [CFG_W-1:0] STEP_ELEVEN_RESET = 16'h000b;
	localparam logic [CFG_W-1:0] WRITABLE_MASK     = 16'he01f;

	// Step configuration fields
	localparam int unsigned ENABLE_BIT = 15;
	localparam int unsigned GAIN_HI    = 14;
	localparam int unsigned GAIN_LO    = 13;
	localparam int unsigned NEG_BIT    = 4;
	localparam int unsigned POS_HI     = 3;
	localparam int unsigned POS_LO     = 0;

	// Positive-select codes
	localparam logic [3:0] POS_LAST_EXTERNAL  = 4'h7;
	localparam logic [3:0] POS_TEMP_SENSOR    = 4'h8;
	localparam logic [3:0] POS_GROUND_SHORT   = 4'h9;
	localparam logic [3:0] POS_TEST_DAC       = 4'ha;
	localparam logic [3:0] POS_ANALOG_SUPPLY  = 4'he;
	localparam logic [3:0] POS_DIGITAL_SUPPLY = 4'hf;
	localparam int unsigned SUPPLY_DIVIDER    = 103;

	// Gain codes and resulting factors
	localparam logic [1:0] GAIN_CODE_ONE = 2'h0;
	localparam logic [1:0] GAIN_CODE_TWO = 2'h1;
	localparam logic [2:0] GAIN_ONE      = 3'h1;
	localparam logic [2:0] GAIN_TWO      = 3'h2;
	localparam logic [2:0] GAIN_FOUR     = 3'h4;

	// Route status register fields
	localparam int unsigned ST_ENABLE_BIT = 0;
	localparam int unsigned ST_GAIN_LO    = 1;
	localparam int unsigned ST_SOURCE_LO  = 4;
	localparam int unsigned ST_NEG_LO     = 7;
	localparam int unsigned ST_EXT_LO     = 9;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SRC_EXTERNAL       = 3'b000,
		SRC_TEMP_SENSOR    = 3'b001,
		SRC_GROUND_SHORT   = 3'b010,
		SRC_TEST_DAC       = 3'b011,
		SRC_ANALOG_SUPPLY  = 3'b100,
		SRC_DIGITAL_SUPPLY = 3'b101,
		SRC_OTHER_INTERNAL = 3'b110
	} ssc_source_type;

	typedef enum logic [1:0] {
		NEG_ANALOG_GROUND = 2'b00,
		NEG_INPUT_SEVEN   = 2'b01,
		NEG_AUTOMATIC     = 2'b10
	} ssc_negative_type;
endpackage

// file: rtl/ssc_route_decode.sv
// Registered decode of one step configuration into converter routing
`timescale 1ns/100ps
`default_nettype none
module ssc_route_decode
	import ssc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [CFG_W-1:0] cfg,
	output logic                  route_enable,
	output logic [2:0]            gain_factor,
	output ssc_source_type        source,
	output logic [2:0]            external_index,
	output ssc_negative_type      negative
);
	wire logic [3:0]       pos_code;
	wire logic [1:0]       gain_code;
	wire logic             is_external;
	wire logic [2:0]       gain_next;
	wire ssc_source_type   source_next;
	wire ssc_negative_type negative_next;

	assign pos_code    = cfg[POS_HI:POS_LO];
	assign gain_code   = cfg[GAIN_HI:GAIN_LO];
	assign is_external = (pos_code <= POS_LAST_EXTERNAL);
	assign gain_next = (gain_code == GAIN_CODE_ONE) ? GAIN_ONE :
	                   (gain_code == GAIN_CODE_TWO) ? GAIN_TWO : GAIN_FOUR;
	// Codes 1011b..1101b are other internal sources, also with automatic negative input
	assign source_next = is_external                      ? SRC_EXTERNAL :
	                     (pos_code == POS_TEMP_SENSOR)    ? SRC_TEMP_SENSOR :
	                     (pos_code == POS_GROUND_SHORT)   ? SRC_GROUND_SHORT :
	                     (pos_code == POS_TEST_DAC)       ? SRC_TEST_DAC :
	                     (pos_code == POS_ANALOG_SUPPLY)  ? SRC_ANALOG_SUPPLY :
	                     (pos_code == POS_DIGITAL_SUPPLY) ? SRC_DIGITAL_SUPPLY :
	                     SRC_OTHER_INTERNAL;
	// Negative-select bit only counts for external inputs
	assign negative_next = !is_external  ? NEG_AUTOMATIC :
	                       cfg[NEG_BIT]  ? NEG_INPUT_SEVEN : NEG_ANALOG_GROUND;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			route_enable   <= 1'b0;
			gain_factor    <= GAIN_ONE;
			source         <= SRC_EXTERNAL;
			external_index <= 3'h0;
			negative       <= NEG_ANALOG_GROUND;
		end else if (ce) begin
			route_enable   <= cfg[ENABLE_BIT];
			gain_factor    <= gain_next;
			source         <= source_next;
			external_index <= pos_code[2:0];
			negative       <= negative_next;
		end
	end
endmodule
`default_nettype wire

// file: rtl/ssc_step_config.sv
// AXI4-Lite register bank holding the step ten and eleven configurations
//
// Notes on behaviour
// - bit 15 enables sequence step ten
// - gain codes 00=1, 01=2, 10/11=4
// - bit 4 picks ground or input seven
// - codes 0000b-0111b pick external inputs zero-seven
// - 1000b temp, 1001b ground short, 1010b DAC
// - 1110b/1111b route supplies divided by 103
// - internal sources ignore the negative-select bit
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ssc_step_config
	import ssc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   step_ten_enable,
	output logic [2:0]             step_ten_gain_factor,
	output ssc_source_type         step_ten_positive_source,
	output logic [2:0]             step_ten_external_index,
	output ssc_negative_type       step_ten_negative_route
);
	function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[ADDR_W-1:2];
	endfunction

	// Byte-lane merge; reserved bits are forced to zero
	function automatic logic [CFG_W-1:0] merge_write(
		input logic [CFG_W-1:0]  old_val,
		input logic [DATA_W-1:0] wdata,
		input logic [3:0]        wstrb
	);
		logic [CFG_W-1:0] merged;
		merged[7:0]  = wstrb[0] ? wdata[7:0] : old_val[7:0];
		merged[15:8] = wstrb[1] ? wdata[15:8] : old_val[15:8];
		merge_write  = merged & WRITABLE_MASK;
	endfunction

	// Release is retimed so every flop leaves reset on the same edge
	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	logic [CFG_W-1:0]  step_ten_reg;
	logic [CFG_W-1:0]  step_eleven_reg;
	logic              aw_held_reg;
	logic [IDX_W-1:0]  aw_index_reg;
	logic              w_held_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [1:0]        rresp_reg;

	wire logic              aw_take;
	wire logic              w_take;
	wire logic              ar_take;
	wire logic              do_write;
	wire logic              wr_step_ten;
	wire logic              wr_step_eleven;
	wire logic              wr_ok;
	wire logic [IDX_W-1:0]  ar_index;
	wire logic              rd_hit;
	wire logic [DATA_W-1:0] rd_data;
	wire logic [DATA_W-1:0] status_word;
	wire logic              b_take;
	wire logic              r_take;
	wire logic [1:0]        bresp_next;
	wire logic [1:0]        rresp_next;

	assign aw_take        = s_axi_awvalid && awready_reg;
	assign w_take         = s_axi_wvalid && wready_reg;
	assign ar_take        = s_axi_arvalid && arready_reg;
	assign do_write       = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_step_ten    = (aw_index_reg == STEP_TEN_INDEX);
	assign wr_step_eleven = (aw_index_reg == STEP_ELEVEN_INDEX);
	assign wr_ok          = wr_step_ten || wr_step_eleven;
	assign ar_index       = reg_index(s_axi_araddr);
	assign rd_hit         = (ar_index == STEP_TEN_INDEX) || (ar_index == STEP_ELEVEN_INDEX) ||
	                        (ar_index == ROUTE_STATUS_INDEX);

	assign b_take     = bvalid_reg && s_axi_bready;
	assign r_take     = rvalid_reg && s_axi_rready;
	assign bresp_next = wr_ok ? RESP_OKAY : RESP_SLVERR;
	assign rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;

	// Status shows the routing that the decoder is currently applying
	assign status_word = DATA_W'({step_ten_external_index, step_ten_negative_route,
	                              step_ten_positive_source, step_ten_gain_factor, step_ten_enable});
	// Upper bits read zero; reserved bits are never stored
	assign rd_data = (ar_index == STEP_TEN_INDEX)    ? DATA_W'(step_ten_reg) :
	                 (ar_index == STEP_ELEVEN_INDEX) ? DATA_W'(step_eleven_reg) :
	                 (ar_index == ROUTE_STATUS_INDEX) ? status_word : '0;

	// Write channel: address and data may arrive in either order
	// Ready stays low until the response is taken, so a held address is never overwritten
	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			aw_held_reg  <= 1'b0;
			aw_index_reg <= '0;
			w_held_reg   <= 1'b0;
			wdata_reg    <= '0;
			wstrb_reg    <= 4'h0;
			awready_reg  <= 1'b1;
			wready_reg   <= 1'b1;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= RESP_OKAY;
		end else if (ce) begin
			if (aw_take) begin
				aw_held_reg  <= 1'b1;
				aw_index_reg <= reg_index(s_axi_awaddr);
				awready_reg  <= 1'b0;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
				wready_reg <= 1'b0;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= bresp_next;
			end
			if (b_take) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			step_ten_reg    <= STEP_TEN_RESET;
			step_eleven_reg <= STEP_ELEVEN_RESET;
		end else if (ce && do_write) begin
			if (wr_step_ten) begin
				step_ten_reg <= merge_write(step_ten_reg, wdata_reg, wstrb_reg);
			end
			if (wr_step_eleven) begin
				step_eleven_reg <= merge_write(step_eleven_reg, wdata_reg, wstrb_reg);
			end
		end
	end

	// Read channel: one read outstanding, answered the cycle after acceptance
	// Data are captured at acceptance, so a later write cannot change an answer in flight
	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				arready_reg <= 1'b0;
				rvalid_reg  <= 1'b1;
				rdata_reg   <= rd_data;
				rresp_reg   <= rresp_next;
			end else if (r_take) begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	ssc_route_decode u_route (
		.clk            (clk),
		.rst_n          (rst_sync_reg),
		.ce             (ce),
		.cfg            (step_ten_reg),
		.route_enable   (step_ten_enable),
		.gain_factor    (step_ten_gain_factor),
		.source         (step_ten_positive_source),
		.external_index (step_ten_external_index),
		.negative       (step_ten_negative_route)
	);
endmodule
`default_nettype wire

// file: tb/ssc_step_config_asserts.sv
// Concurrent checks of the step ten register read-back against its routing outputs
`timescale 1ns/100ps
`default_nettype none
module ssc_step_config_asserts
	import ssc_pkg::*;
(
	input wire logic		clk,
	input wire logic		rstn,
	input wire logic		ce,
	input wire logic [ADDR_W-1:0]	s_axi_araddr,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic		s_axi_awready,
	input wire logic		s_axi_rvalid,
	input wire logic [DATA_W-1:0]	s_axi_rdata,
	input wire logic		step_ten_enable,
	input wire logic [2:0]		step_ten_gain_factor,
	input wire ssc_source_type	step_ten_positive_source,
	input wire logic [2:0]		step_ten_external_index,
	input wire ssc_negative_type	step_ten_negative_route
);
	logic		rd_ten_reg;
	logic [15:0]	d;
	assign d = s_axi_rdata[15:0];
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rd_ten_reg <= 1'h0;
		else if (ce && s_axi_arvalid && s_axi_arready)
			rd_ten_reg <= (s_axi_araddr[ADDR_W-1:2] == STEP_TEN_INDEX);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Fresh step ten read with no write stored at that edge, so outputs decode the same word
	sequence s_rd; $rose(s_axi_rvalid) && rd_ten_reg && $past(s_axi_awready); endsequence
	property p_enable; s_rd |-> step_ten_enable == d[15]; endproperty
	property p_gain; s_rd |-> step_ten_gain_factor == (d[14] ? GAIN_FOUR : d[13] ? GAIN_TWO : GAIN_ONE); endproperty
	property p_neg; s_rd ##0 !d[3] |-> step_ten_negative_route == (d[4] ? NEG_INPUT_SEVEN : NEG_ANALOG_GROUND);
	endproperty
	property p_ext; s_rd ##0 !d[3] |-> step_ten_positive_source == SRC_EXTERNAL && step_ten_external_index == d[2:0];
	endproperty
	property p_internal; s_rd ##0 (d[3:2] == 2'h2 && d[1:0] != 2'h3) |->
		step_ten_positive_source == (d[1] ? SRC_TEST_DAC : d[0] ? SRC_GROUND_SHORT : SRC_TEMP_SENSOR); endproperty
	property p_supply; s_rd ##0 d[3:1] == 3'h7 |->
		step_ten_positive_source == (d[0] ? SRC_DIGITAL_SUPPLY : SRC_ANALOG_SUPPLY); endproperty
	property p_auto; s_rd ##0 d[3] |-> step_ten_negative_route == NEG_AUTOMATIC; endproperty
	property p_reserved; s_axi_rvalid && rd_ten_reg |-> d[12:5] == 8'h00 && s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_enable: assert property (p_enable) else $error("enable output differs");
	a_gain: assert property (p_gain) else $error("gain output differs");
	a_neg: assert property (p_neg) else $error("negative route differs");
	a_ext: assert property (p_ext) else $error("external route differs");
	a_internal: assert property (p_internal) else $error("internal source differs");
	a_supply: assert property (p_supply) else $error("supply source differs");
	a_auto: assert property (p_auto) else $error("negative not automatic");
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
	c_internal: cover property (s_rd ##0 d[3]);
	c_seven: cover property (s_rd ##0 (!d[3] && d[4]));
	c_enabled: cover property (s_rd ##0 d[15]);
endmodule
bind ssc_step_config ssc_step_config_asserts u_chk (.clk, .rstn, .ce, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_awready, .s_axi_rvalid, .s_axi_rdata, .step_ten_enable, .step_ten_gain_factor,
	.step_ten_positive_source, .step_ten_external_index, .step_ten_negative_route);
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the step configuration register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
	import ssc_pkg::*;
;
	localparam logic [11:0] A10 = {STEP_TEN_INDEX, 2'h0};
	localparam logic [11:0] AST = {ROUTE_STATUS_INDEX, 2'h0};
	logic			clk = 0, rstn = 0, ce = 1;
	logic [ADDR_W-1:0]	s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0]		s_axi_awprot = '0, s_axi_arprot = '0;
	logic			s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [DATA_W-1:0]	s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]		s_axi_wstrb = '0;
	logic			s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]		s_axi_bresp, s_axi_rresp, eb;
	logic [33:0]		er;
	logic [1:0]		qb[$];
	logic [33:0]		qr[$];
	logic [15:0]		cur;
	int			n_fail = 0, tests_run = 0, cyc = 0, seed = 64655;
	ssc_step_config uut (.clk, .rstn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.step_ten_enable(), .step_ten_gain_factor(), .step_ten_positive_source(), .step_ten_external_index(),
		.step_ten_negative_route());
	always #50 clk = ~clk;
	// Clock enable drops at random, so handshakes also meet frozen cycles
	always @(posedge clk) ce <= ($random(seed) & 3) != 0;
	// Routing status expected for a configuration word
	function automatic logic [11:0] st(input logic [15:0] c);
		logic [2:0] src;
		logic [1:0] n;
		logic [2:0] g;
		g = c[14] ? GAIN_FOUR : c[13] ? GAIN_TWO : GAIN_ONE;
		case (c[3:0])
			4'h8: src = SRC_TEMP_SENSOR;
			4'h9: src = SRC_GROUND_SHORT;
			4'ha: src = SRC_TEST_DAC;
			4'he: src = SRC_ANALOG_SUPPLY;
			4'hf: src = SRC_DIGITAL_SUPPLY;
			default: src = c[3] ? SRC_OTHER_INTERNAL : SRC_EXTERNAL;
		endcase
		n = c[3] ? NEG_AUTOMATIC : c[4] ? NEG_INPUT_SEVEN : NEG_ANALOG_GROUND;
		st = {c[2:0], n, src, g, c[15]};
	endfunction
	task automatic results();
		if (n_fail == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Address and data are offered together; each is dropped at the edge that takes it
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		@(posedge clk);
		qb.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awprot <= 3'($random(seed));
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready && ce) s_axi_awvalid <= 1'h0;
			if (s_axi_wready && ce) s_axi_wvalid <= 1'h0;
		end while (!(s_axi_bvalid && ce));
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		@(posedge clk);
		qr.push_back(e);
		s_axi_araddr <= a;
		s_axi_arprot <= 3'($random(seed));
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready && ce) s_axi_arvalid <= 1'h0;
		end while (!(s_axi_rvalid && ce));
		s_axi_rready <= 1'h0;
	endtask
	// Only bits 15:13 and 4:0 are storable; byte lanes 3:2 carry nothing
	task automatic wr10(input logic [31:0] d, input logic [3:0] s);
		logic [15:0] m;
		m = {{8{s[1]}}, {8{s[0]}}} & 16'he01f;
		cur = (cur & ~m) | (d[15:0] & m);
		wr(A10, d, s, RESP_OKAY);
		rd(A10, {RESP_OKAY, 16'h0000, cur});
		rd(AST, {RESP_OKAY, 20'h0_0000, st(cur)});
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ce && s_axi_bvalid && s_axi_bready) begin
			eb = qb.pop_front();
			`CHK(s_axi_bresp, eb)
		end
		if (ce && s_axi_rvalid && s_axi_rready) begin
			er = qr.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, er)
		end
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		logic [31:0] d;
		// Second pass repeats everything after a reset in mid-run
		for (int k = 0; k < 2; k++) begin
			rstn <= 1'h0;
			repeat (6) @(posedge clk);
			rstn <= 1'h1;
			repeat (3) @(posedge clk);
			cur = 16'h000a;
			rd(A10, {RESP_OKAY, 16'h0000, cur});
			rd({STEP_ELEVEN_INDEX, 2'h0}, {RESP_OKAY, 32'h0000_000b});
			rd(AST, {RESP_OKAY, 20'h0_0000, st(cur)});
			// Every positive code with both negative-select values, random gain and enable
			for (int i = 0; i < 32; i++) begin
				d = $random(seed);
				d[4:0] = i[4:0];
				wr10(d, 4'hf);
			end
			wr10($random(seed), 4'h2);
			wr10($random(seed), 4'h1);
			wr10($random(seed), 4'hc);
			wr({ROUTE_STATUS_INDEX, 2'h0}, $random(seed), 4'hf, RESP_SLVERR);
			wr(12'hffc, $random(seed), 4'hf, RESP_SLVERR);
			rd(12'hffc, {RESP_SLVERR, 32'h0000_0000});
			rd(A10, {RESP_OKAY, 16'h0000, cur});
		end
		results();
	end
endmodule
`default_nettype wire
